// File: logic/kbm_cfg_pkg.sv
// Package of offsets, reset values and field layouts for the controller config bank
`default_nettype none
package kbm_cfg_pkg;
  // Register indexes inside one logical-device bank
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_DATA_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_DATA_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_CMD_BASE_HIGH = 8'h62;
  localparam logic [7:0] IDX_CMD_BASE_LOW = 8'h63;
  localparam logic [7:0] IDX_IRQ_NUMBER = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA_REPORT_A = 8'h74;
  localparam logic [7:0] IDX_DMA_REPORT_B = 8'h75;
  localparam logic [7:0] IDX_SHARED_CONFIG = 8'hF0;
  // Bank select: byte address = bank * 0x400 + 4 * index
  localparam int BANK_BIT = 10;
  localparam logic BANK_MOUSE = 1'b0;
  localparam logic BANK_KEYBOARD = 1'b1;
  // Reset values
  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_BASE_HIGH = 8'h00;
  localparam logic [7:0] RST_DATA_BASE_LOW = 8'h60;
  localparam logic [7:0] RST_CMD_BASE_LOW = 8'h64;
  localparam logic [7:0] RST_MOUSE_IRQ_NUMBER = 8'h0C;
  localparam logic [7:0] RST_KBD_IRQ_NUMBER = 8'h01;
  localparam logic [7:0] RST_IRQ_TYPE = 8'h02;
  localparam logic [7:0] DMA_REPORT_NONE = 8'h04;
  localparam logic [1:0] RST_CLK_SEL = 2'h1;
  // Fixed fields and writable masks
  localparam logic [2:0] DATA_LOW_FIXED = 3'h0;
  localparam logic [2:0] CMD_LOW_FIXED = 3'h4;
  localparam logic [7:0] BASE_HIGH_WMASK = 8'h07;
  localparam logic [7:0] IRQ_TYPE_WMASK = 8'h03;
  // Shared config field positions
  localparam int CFG_CLK_MSB = 7;
  localparam int CFG_CLK_LSB = 6;
  localparam int CFG_SWAP_BIT = 3;
  localparam int CFG_HIZ_BIT = 0;
  localparam int ACT_BIT = 0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Controller clock choices
  typedef enum logic [1:0] {
    KBM_CLK_8MHZ = 2'b00,
    KBM_CLK_12MHZ = 2'b01,
    KBM_CLK_16MHZ = 2'b10,
    KBM_CLK_RSVD = 2'b11
  } kbm_clk_e;
  // Decoded register selection
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000, SEL_M_ACT = 4'b0001, SEL_K_ACT = 4'b0010,
    SEL_DB_HI = 4'b0011, SEL_DB_LO = 4'b0100, SEL_CB_HI = 4'b0101,
    SEL_CB_LO = 4'b0110, SEL_M_NUM = 4'b0111, SEL_K_NUM = 4'b1000,
    SEL_M_TYPE = 4'b1001, SEL_K_TYPE = 4'b1010, SEL_DMA = 4'b1011,
    SEL_CFG = 4'b1100
  } kbm_sel_e;
endpackage : kbm_cfg_pkg
`default_nettype wire

// File: logic/kbm_pin_if.sv
// Interface carrying controller-side pin requests and routing control to the pin mux
`timescale 1ns/100ps
`default_nettype none
interface kbm_pin_if;
  logic kb_clk_low;
  logic kb_dat_low;
  logic ms_clk_low;
  logic ms_dat_low;
  logic kb_clk_rx;
  logic kb_dat_rx;
  logic ms_clk_rx;
  logic ms_dat_rx;
  logic swap;
  logic hiz;
  modport cfg (output kb_clk_low, kb_dat_low, ms_clk_low, ms_dat_low, swap, hiz,
               input kb_clk_rx, kb_dat_rx, ms_clk_rx, ms_dat_rx);
  modport mux (input kb_clk_low, kb_dat_low, ms_clk_low, ms_dat_low, swap, hiz,
               output kb_clk_rx, kb_dat_rx, ms_clk_rx, ms_dat_rx);
endinterface : kbm_pin_if
`default_nettype wire

// File: logic/kbm_pin_mux.sv
// Open-drain pin exchange and high-impedance control for the keyboard and pointer pins
`timescale 1ns/100ps
`default_nettype none
module kbm_pin_mux
  import kbm_cfg_pkg::*;
(
  // Controller side
  kbm_pin_if.mux ctl,
  // Keyboard clock pin
  input wire logic keyboard_clock_pin_in,
  output logic keyboard_clock_pin_out,
  output logic keyboard_clock_pin_oe_n_out,
  // Keyboard data pin
  input wire logic keyboard_data_pin_in,
  output logic keyboard_data_pin_out,
  output logic keyboard_data_pin_oe_n_out,
  // Pointer clock pin
  input wire logic pointer_clock_pin_in,
  output logic pointer_clock_pin_out,
  output logic pointer_clock_pin_oe_n_out,
  // Pointer data pin
  input wire logic pointer_data_pin_in,
  output logic pointer_data_pin_out,
  output logic pointer_data_pin_oe_n_out
);
  // Open drain: the pins only ever pull low, so the driven level is constant
  assign keyboard_clock_pin_out = 1'b0;
  assign keyboard_data_pin_out = 1'b0;
  assign pointer_clock_pin_out = 1'b0;
  assign pointer_data_pin_out = 1'b0;

  assign keyboard_clock_pin_oe_n_out = ctl.hiz | ~(ctl.swap ? ctl.ms_clk_low : ctl.kb_clk_low);
  assign keyboard_data_pin_oe_n_out = ctl.hiz | ~(ctl.swap ? ctl.ms_dat_low : ctl.kb_dat_low);
  assign pointer_clock_pin_oe_n_out = ctl.hiz | ~(ctl.swap ? ctl.kb_clk_low : ctl.ms_clk_low);
  assign pointer_data_pin_oe_n_out = ctl.hiz | ~(ctl.swap ? ctl.kb_dat_low : ctl.ms_dat_low);

  // receive path follows the same exchange
  assign ctl.kb_clk_rx = ctl.swap ? pointer_clock_pin_in : keyboard_clock_pin_in;
  assign ctl.kb_dat_rx = ctl.swap ? pointer_data_pin_in : keyboard_data_pin_in;
  assign ctl.ms_clk_rx = ctl.swap ? keyboard_clock_pin_in : pointer_clock_pin_in;
  assign ctl.ms_dat_rx = ctl.swap ? keyboard_data_pin_in : pointer_data_pin_in;
endmodule // kbm_pin_mux
`default_nettype wire

// File: logic/kbm_config.sv
// Configuration bank of the keyboard and pointer controller, reached over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module kbm_config
  import kbm_cfg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and resets
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic sb_srst_in,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller resources
  output logic kbc_active_out,
  output logic [15:0] kbd_data_base_out,
  output logic [15:0] kbd_cmd_base_out,
  output logic [1:0] kbc_clk_sel_out,
  output logic wakeup_swap_out,
  // Interrupt requests in, gated lines out
  input wire logic mouse_irq_req_in,
  input wire logic kbd_irq_req_in,
  output logic mouse_irq_out,
  output logic kbd_irq_out,
  output logic [7:0] mouse_irq_num_out,
  output logic [7:0] kbd_irq_num_out,
  output logic [1:0] mouse_irq_type_out,
  output logic [1:0] kbd_irq_type_out,
  // Controller-side pin requests (high pulls the line low)
  input wire logic kb_clk_low_in,
  input wire logic kb_dat_low_in,
  input wire logic ms_clk_low_in,
  input wire logic ms_dat_low_in,
  output logic kb_clk_rx_out,
  output logic kb_dat_rx_out,
  output logic ms_clk_rx_out,
  output logic ms_dat_rx_out,
  // Keyboard pins
  input wire logic keyboard_clock_pin_in,
  output logic keyboard_clock_pin_out,
  output logic keyboard_clock_pin_oe_n_out,
  input wire logic keyboard_data_pin_in,
  output logic keyboard_data_pin_out,
  output logic keyboard_data_pin_oe_n_out,
  // Pointer pins
  input wire logic pointer_clock_pin_in,
  output logic pointer_clock_pin_out,
  output logic pointer_clock_pin_oe_n_out,
  input wire logic pointer_data_pin_in,
  output logic pointer_data_pin_out,
  output logic pointer_data_pin_oe_n_out
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Shared by read and write paths; anything unlisted is unmapped
  function automatic kbm_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic bank;
    idx = addr[9:2];
    bank = addr[BANK_BIT];
    reg_sel = SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[ADDR_W-1:BANK_BIT+1] == '0) begin
      case (idx)
        IDX_ACTIVATE: reg_sel = (bank == BANK_MOUSE) ? SEL_M_ACT : SEL_K_ACT;
        IDX_DATA_BASE_HIGH: reg_sel = (bank == BANK_KEYBOARD) ? SEL_DB_HI : SEL_NONE;
        IDX_DATA_BASE_LOW: reg_sel = (bank == BANK_KEYBOARD) ? SEL_DB_LO : SEL_NONE;
        IDX_CMD_BASE_HIGH: reg_sel = (bank == BANK_KEYBOARD) ? SEL_CB_HI : SEL_NONE;
        IDX_CMD_BASE_LOW: reg_sel = (bank == BANK_KEYBOARD) ? SEL_CB_LO : SEL_NONE;
        IDX_IRQ_NUMBER: reg_sel = (bank == BANK_MOUSE) ? SEL_M_NUM : SEL_K_NUM;
        IDX_IRQ_TYPE: reg_sel = (bank == BANK_MOUSE) ? SEL_M_TYPE : SEL_K_TYPE;
        IDX_DMA_REPORT_A, IDX_DMA_REPORT_B: reg_sel = SEL_DMA;
        IDX_SHARED_CONFIG: reg_sel = (bank == BANK_KEYBOARD) ? SEL_CFG : SEL_NONE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic wr_fire;
  kbm_sel_e wr_sel;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_sel = reg_sel(aw_addr_reg);

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic mouse_act_reg;
  logic kbd_act_reg;
  logic [2:0] data_base_high_reg;
  logic [4:0] data_base_low_reg;
  logic [2:0] cmd_base_high_reg;
  logic [4:0] cmd_base_low_reg;
  logic [7:0] mouse_irq_num_reg;
  logic [7:0] kbd_irq_num_reg;
  logic [1:0] mouse_irq_type_reg;
  logic [1:0] kbd_irq_type_reg;
  logic [1:0] clk_sel_reg;
  logic hiz_reg;
  logic swap_reg;
  logic wr_byte;
  logic any_active;

  assign wr_byte = wr_fire & w_lane_reg;
  assign any_active = mouse_act_reg | kbd_act_reg;

  // Activation bits; only bit 0 is stored
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mouse_act_reg <= RST_ACTIVATE[ACT_BIT];
      kbd_act_reg <= RST_ACTIVATE[ACT_BIT];
    end else if (wr_byte) begin
      if (wr_sel == SEL_M_ACT) mouse_act_reg <= w_data_reg[ACT_BIT];
      if (wr_sel == SEL_K_ACT) kbd_act_reg <= w_data_reg[ACT_BIT];
    end
  end

  // base addresses; fixed bits are never stored
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_base_high_reg <= RST_BASE_HIGH[2:0];
      data_base_low_reg <= RST_DATA_BASE_LOW[7:3];
      cmd_base_high_reg <= RST_BASE_HIGH[2:0];
      cmd_base_low_reg <= RST_CMD_BASE_LOW[7:3];
    end else if (wr_byte) begin
      if (wr_sel == SEL_DB_HI) data_base_high_reg <= w_data_reg[2:0];
      if (wr_sel == SEL_DB_LO) data_base_low_reg <= w_data_reg[7:3];
      if (wr_sel == SEL_CB_HI) cmd_base_high_reg <= w_data_reg[2:0];
      if (wr_sel == SEL_CB_LO) cmd_base_low_reg <= w_data_reg[7:3];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mouse_irq_num_reg <= RST_MOUSE_IRQ_NUMBER;
      kbd_irq_num_reg <= RST_KBD_IRQ_NUMBER;
      mouse_irq_type_reg <= RST_IRQ_TYPE[1:0];
      kbd_irq_type_reg <= RST_IRQ_TYPE[1:0];
    end else if (wr_byte) begin
      if (wr_sel == SEL_M_NUM) mouse_irq_num_reg <= w_data_reg;
      if (wr_sel == SEL_K_NUM) kbd_irq_num_reg <= w_data_reg;
      if (wr_sel == SEL_M_TYPE) mouse_irq_type_reg <= w_data_reg[1:0];
      if (wr_sel == SEL_K_TYPE) kbd_irq_type_reg <= w_data_reg[1:0];
    end
  end

  // clock field frozen while active; a write then leaves it unchanged
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      clk_sel_reg <= RST_CLK_SEL;
      hiz_reg <= 1'b0;
    end else if (wr_byte && wr_sel == SEL_CFG) begin
      if (!any_active) clk_sel_reg <= w_data_reg[CFG_CLK_MSB:CFG_CLK_LSB];
      hiz_reg <= w_data_reg[CFG_HIZ_BIT];
    end
  end

  // standby-well bit: main reset does not clear it
  // A write landing in a main-reset cycle is dropped, as it is for every other register
  always_ff @(posedge clk_in) begin
    if (sb_srst_in) begin
      swap_reg <= 1'b0;
    end else if (!srst_in && wr_byte && wr_sel == SEL_CFG) begin
      swap_reg <= w_data_reg[CFG_SWAP_BIT];
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [7:0] rd_byte;
  kbm_sel_e rd_sel;
  assign rd_sel = reg_sel(s_axi_araddr);
  assign s_axi_arready = ~s_axi_rvalid;

  // Read mux; reserved config bits come back zero
  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      SEL_M_ACT: rd_byte = {7'h00, mouse_act_reg};
      SEL_K_ACT: rd_byte = {7'h00, kbd_act_reg};
      SEL_DB_HI: rd_byte = {5'h00, data_base_high_reg};
      SEL_DB_LO: rd_byte = {data_base_low_reg, DATA_LOW_FIXED};
      SEL_CB_HI: rd_byte = {5'h00, cmd_base_high_reg};
      SEL_CB_LO: rd_byte = {cmd_base_low_reg, CMD_LOW_FIXED};
      SEL_M_NUM: rd_byte = mouse_irq_num_reg;
      SEL_K_NUM: rd_byte = kbd_irq_num_reg;
      SEL_M_TYPE: rd_byte = {6'h00, mouse_irq_type_reg};
      SEL_K_TYPE: rd_byte = {6'h00, kbd_irq_type_reg};
      SEL_DMA: rd_byte = DMA_REPORT_NONE;
      SEL_CFG: rd_byte = {clk_sel_reg, 2'h0, swap_reg, 2'h0, hiz_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // One-deep read: data registered on the address handshake
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Controller resources
  // ----------------------------------------
  assign kbc_active_out = any_active;
  assign kbd_data_base_out = {5'h00, data_base_high_reg, data_base_low_reg, DATA_LOW_FIXED};
  assign kbd_cmd_base_out = {5'h00, cmd_base_high_reg, cmd_base_low_reg, CMD_LOW_FIXED};
  assign kbc_clk_sel_out = clk_sel_reg;
  // wake-up detector sees the same swap
  assign wakeup_swap_out = swap_reg;
  // each line gated by its own device only
  assign mouse_irq_out = mouse_irq_req_in & mouse_act_reg;
  assign kbd_irq_out = kbd_irq_req_in & kbd_act_reg;
  assign mouse_irq_num_out = mouse_irq_num_reg;
  assign kbd_irq_num_out = kbd_irq_num_reg;
  assign mouse_irq_type_out = mouse_irq_type_reg;
  assign kbd_irq_type_out = kbd_irq_type_reg;

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  kbm_pin_if pin_bus ();
  assign pin_bus.kb_clk_low = kb_clk_low_in;
  assign pin_bus.kb_dat_low = kb_dat_low_in;
  assign pin_bus.ms_clk_low = ms_clk_low_in;
  assign pin_bus.ms_dat_low = ms_dat_low_in;
  assign pin_bus.swap = swap_reg;
  // float only when both devices are off
  assign pin_bus.hiz = hiz_reg & ~any_active;
  assign kb_clk_rx_out = pin_bus.kb_clk_rx;
  assign kb_dat_rx_out = pin_bus.kb_dat_rx;
  assign ms_clk_rx_out = pin_bus.ms_clk_rx;
  assign ms_dat_rx_out = pin_bus.ms_dat_rx;

  kbm_pin_mux u_pin_mux (
    .ctl(pin_bus.mux),
    .keyboard_clock_pin_in(keyboard_clock_pin_in),
    .keyboard_clock_pin_out(keyboard_clock_pin_out),
    .keyboard_clock_pin_oe_n_out(keyboard_clock_pin_oe_n_out),
    .keyboard_data_pin_in(keyboard_data_pin_in),
    .keyboard_data_pin_out(keyboard_data_pin_out),
    .keyboard_data_pin_oe_n_out(keyboard_data_pin_oe_n_out),
    .pointer_clock_pin_in(pointer_clock_pin_in),
    .pointer_clock_pin_out(pointer_clock_pin_out),
    .pointer_clock_pin_oe_n_out(pointer_clock_pin_oe_n_out),
    .pointer_data_pin_in(pointer_data_pin_in),
    .pointer_data_pin_out(pointer_data_pin_out),
    .pointer_data_pin_oe_n_out(pointer_data_pin_oe_n_out)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence rd_take_dma_s;
    s_axi_arvalid && s_axi_arready && rd_sel == SEL_DMA;
  endsequence
  sequence rd_answer_dma_s;
    s_axi_rvalid && s_axi_rdata == 32'h0000_0004 && s_axi_rresp == RESP_OKAY;
  endsequence
  sequence cfg_write_active_s;
    wr_byte && wr_sel == SEL_CFG && any_active;
  endsequence
  sequence rd_take_cfg_s;
    s_axi_arvalid && s_axi_arready && rd_sel == SEL_CFG;
  endsequence

  active_or_a: assert property (kbc_active_out == (mouse_act_reg | kbd_act_reg))
    else $error("controller active does not follow activations");
  irq_split_a: assert property (mouse_irq_req_in && !kbd_act_reg && mouse_act_reg
    |-> mouse_irq_out && !kbd_irq_out)
    else $error("interrupts not kept per device");
  mouse_irq_gate_a: assert property (!mouse_act_reg |-> !mouse_irq_out)
    else $error("pointer interrupt while inactive");
  kbd_irq_gate_a: assert property (!kbd_act_reg |-> !kbd_irq_out)
    else $error("keyboard interrupt while inactive");
  data_low_fix_a: assert property (kbd_data_base_out[2:0] == 3'h0)
    else $error("data base low bits not zero");
  cmd_low_fix_a: assert property (kbd_cmd_base_out[2:0] == 3'h4)
    else $error("command base low bits not 100");
  base_high_fix_a: assert property (kbd_data_base_out[15:11] == 5'h00
    && kbd_cmd_base_out[15:11] == 5'h00)
    else $error("base high bits above A10 set");
  irq_num_rst_a: assert property ($past(srst_in) |-> mouse_irq_num_out == 8'h0C
    && kbd_irq_num_out == 8'h01 && kbc_clk_sel_out == 2'h1)
    else $error("reset values wrong after reset");
  irq_type_wr_a: assert property (wr_byte && wr_sel == SEL_M_TYPE
    |=> mouse_irq_type_out == $past(w_data_reg[1:0]))
    else $error("interrupt type write lost");
  dma_read_a: assert property (rd_take_dma_s |=> rd_answer_dma_s)
    else $error("DMA report not 04h");
  clk_lock_a: assert property (cfg_write_active_s |=> $stable(kbc_clk_sel_out))
    else $error("clock field changed while active");
  swap_route_a: assert property (swap_reg && !pin_bus.hiz && kb_clk_low_in
    |-> !pointer_clock_pin_oe_n_out)
    else $error("keyboard clock not moved to pointer pin");
  swap_keep_a: assert property (@(posedge clk_in) disable iff (sb_srst_in)
    srst_in |=> $stable(wakeup_swap_out))
    else $error("main reset disturbed swap bit");
  hiz_pins_a: assert property (hiz_reg && !any_active |-> keyboard_clock_pin_oe_n_out
    && keyboard_data_pin_oe_n_out && pointer_clock_pin_oe_n_out
    && pointer_data_pin_oe_n_out)
    else $error("pins driven while floated");
  wr_resp_a: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  cfg_rsvd_a: assert property (rd_take_cfg_s |=> s_axi_rdata[5:4] == 2'h0
    && s_axi_rdata[2:1] == 2'h0)
    else $error("reserved config bits not zero");
endmodule // kbm_config
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the keyboard and pointer configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import kbm_cfg_pkg::*;
  logic clk_in = 0, srst_in = 1, sb_srst_in = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, kbc_clk_sel_out, mouse_irq_type_out, kbd_irq_type_out;
  logic [15:0] kbd_data_base_out, kbd_cmd_base_out;
  logic [7:0] mouse_irq_num_out, kbd_irq_num_out, d;
  logic kbc_active_out, wakeup_swap_out, mouse_irq_out, kbd_irq_out;
  logic mouse_irq_req_in = 0, kbd_irq_req_in = 0;
  logic kb_clk_low_in = 0, kb_dat_low_in = 0, ms_clk_low_in = 0, ms_dat_low_in = 0;
  logic kb_clk_rx_out, kb_dat_rx_out, ms_clk_rx_out, ms_dat_rx_out;
  logic keyboard_clock_pin_out, keyboard_data_pin_out, pointer_clock_pin_out, pointer_data_pin_out;
  logic keyboard_clock_pin_oe_n_out, keyboard_data_pin_oe_n_out;
  logic pointer_clock_pin_oe_n_out, pointer_data_pin_oe_n_out;
  // Pulled-up open-drain lines: high unless the pin is driven low
  wire logic keyboard_clock_pin_in = keyboard_clock_pin_oe_n_out;
  wire logic keyboard_data_pin_in = keyboard_data_pin_oe_n_out;
  wire logic pointer_clock_pin_in = pointer_clock_pin_oe_n_out;
  wire logic pointer_data_pin_in = pointer_data_pin_oe_n_out;
  int n_fail = 0, n_tests = 0, i;
  logic [11:0] ra [15] = '{12'h0C0, 12'h4C0, 12'h580, 12'h584, 12'h588, 12'h58C, 12'h1C0,
    12'h5C0, 12'h1C4, 12'h5C4, 12'h1D0, 12'h1D4, 12'h5D0, 12'h5D4, 12'h7C0};
  logic [7:0] re [15] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h64, 8'h0C, 8'h01, 8'h02,
    8'h02, 8'h04, 8'h04, 8'h04, 8'h04, 8'h40};
  kbm_config i_kbm_config (.*);
  always #2.5 clk_in = ~clk_in;
  // ----------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One write (w=1) or read; holds each valid until its ready is seen
  task automatic bus(input bit w, input logic [11:0] a, input logic [7:0] v);
    int n;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    if (n == 40) chk(0, 1);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk(rd, {24'h0, e});
    chk(rs, RESP_OKAY);
  endtask
  // Readback of a written byte at table entry k
  function automatic logic [7:0] ex(int k, logic [7:0] v);
    case (k)
      2, 4: return v & BASE_HIGH_WMASK;
      3: return {v[7:3], DATA_LOW_FIXED};
      5: return {v[7:3], CMD_LOW_FIXED};
      6, 7: return v;
      8, 9: return v & IRQ_TYPE_WMASK;
      default: return v & 8'hC9;
    endcase
  endfunction
  // Expected {oe_n, rx} of the four pins for low requests {kc, kd, mc, md}
  function automatic logic [7:0] pins(logic [3:0] lo, logic sw, logic hz);
    logic [3:0] oe;
    oe = hz ? 4'hF : ~(sw ? {lo[1:0], lo[3:2]} : lo);
    return {oe, sw ? {oe[1:0], oe[3:2]} : oe};
  endfunction
  // Random pin requests checked against routing; leaves only the keyboard clock pulled
  task automatic pc(input logic sw, input logic hz);
    logic [3:0] lo;
    repeat (4) begin
      @(posedge clk_in);
      lo = 4'($urandom);
      {kb_clk_low_in, kb_dat_low_in, ms_clk_low_in, ms_dat_low_in} <= lo;
      #1 chk({keyboard_clock_pin_out, keyboard_data_pin_out, pointer_clock_pin_out,
        pointer_data_pin_out, keyboard_clock_pin_oe_n_out, keyboard_data_pin_oe_n_out,
        pointer_clock_pin_oe_n_out, pointer_data_pin_oe_n_out, kb_clk_rx_out, kb_dat_rx_out,
        ms_clk_rx_out, ms_dat_rx_out}, {4'h0, pins(lo, sw, hz)});
    end
    @(posedge clk_in);
    {kb_clk_low_in, kb_dat_low_in, ms_clk_low_in, ms_dat_low_in} <= 4'h8;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rd = $urandom(32'h2255);
    repeat (3) @(posedge clk_in);
    srst_in <= 0;
    sb_srst_in <= 0;
    mouse_irq_req_in <= 1;
    kbd_irq_req_in <= 1;
    kb_clk_low_in <= 1;
    for (i = 0; i < 15; i++) rc(ra[i], re[i]);
    chk({mouse_irq_out, kbd_irq_out, kbc_active_out}, 0);
    chk({kbd_data_base_out, kbd_cmd_base_out}, 32'h0060_0064);
    chk({mouse_irq_num_out, kbd_irq_num_out}, 16'h0C01);
    chk({mouse_irq_type_out, kbd_irq_type_out, kbc_clk_sel_out}, 6'h29);
    repeat (3) for (i = 2; i < 15; i++) if (i < 10 || i == 14) begin
      d = 8'($urandom);
      bus(1, ra[i], d);
      rc(ra[i], ex(i, d));
    end
    chk({kbd_cmd_base_out[15:11], kbd_cmd_base_out[2:0]}, 8'h04);
    bus(1, 12'h5D4, 8'hFF);
    rc(12'h5D4, DMA_REPORT_NONE);
    bus(0, 12'h006, 8'h00);
    chk(rs, RESP_DECERR);
    chk(rd, 0);
    bus(1, 12'h7C0, 8'h01);
    #1 chk({keyboard_clock_pin_oe_n_out, kbc_clk_sel_out}, 3'b100);
    pc(0, 1);
    bus(1, 12'h4C0, 8'h01);
    #1 chk({kbc_active_out, keyboard_clock_pin_oe_n_out, kbd_irq_out, mouse_irq_out}, 4'hA);
    bus(1, 12'h7C0, 8'h81);
    rc(12'h7C0, 8'h01);
    // Swap only with both devices off and pins floated, then reactivate
    bus(1, 12'h4C0, 8'h00);
    bus(1, 12'h7C0, 8'h09);
    bus(1, 12'h4C0, 8'h01);
    #1 chk({wakeup_swap_out, pointer_clock_pin_oe_n_out, keyboard_clock_pin_oe_n_out}, 3'b101);
    chk({kb_clk_rx_out, ms_clk_rx_out}, 2'b01);
    pc(1, 0);
    @(posedge clk_in);
    srst_in <= 1;
    @(posedge clk_in);
    srst_in <= 0;
    #1 chk({wakeup_swap_out, kbc_active_out}, 2'b10);
    bus(1, 12'h0C0, 8'h01);
    #1 chk({mouse_irq_out, kbd_irq_out, kbc_active_out}, 3'b101);
    @(posedge clk_in);
    sb_srst_in <= 1;
    @(posedge clk_in);
    sb_srst_in <= 0;
    #1 chk({wakeup_swap_out, keyboard_clock_pin_oe_n_out}, 2'b00);
    pc(0, 0);
    end_of_test;
  end
  // Watchdog: the sequence needs well under 4000 cycles
  initial begin
    #20000;
    n_fail++;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
